// ### src/oabf_consts.vh
`ifndef OABF_CONSTS_VH
`define OABF_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OABF_ADDR_STATUS      8'h00
`define OABF_ADDR_RUN_MODE    8'h14
`define OABF_ADDR_ORIENT      8'h15
`define OABF_ADDR_CONFIG2     8'h16
`define OABF_ADDR_CONFIG4     8'h17
`define OABF_ADDR_INT_EN      8'h18
`define OABF_ADDR_PIN_SEL     8'h19
`define OABF_ADDR_LIMIT_LOW   8'h1A
`define OABF_ADDR_LIMIT_HIGH  8'h1B

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OABF_ST_ORIENT_BIT    2
`define OABF_ST_ASLP_BIT      1
`define OABF_ST_BOOT_BIT      0
`define OABF_EN_BOOT_BIT      0
`define OABF_EN_ASLP_BIT      1
`define OABF_C4_POL_BIT       0
`define OABF_C4_OD_BIT        1
`define OABF_PS_BOOT2_BIT     0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OABF_CONFIG2_RST      8'h00
`define OABF_CONFIG4_RST      8'h00
`define OABF_INT_EN_RST       8'h01
`define OABF_PIN_SEL_RST      8'h00
`define OABF_LIMIT_RST        16'h0000

// ----------------------------------------------------------------
// timing: times in their own unit, counts derived at 10 ns
// ----------------------------------------------------------------
`define OABF_CLK_NS           10
`define OABF_BOOT_US          20
`define OABF_BOOT_CYC         ((`OABF_BOOT_US * 1000) / `OABF_CLK_NS)
`define OABF_PULSE_SHORT_US   10
`define OABF_PULSE_SHORT_CYC  ((`OABF_PULSE_SHORT_US * 1000) / `OABF_CLK_NS)
`define OABF_PULSE_LONG_MS    1
`define OABF_PULSE_LONG_CYC   ((`OABF_PULSE_LONG_MS * 1000000) / `OABF_CLK_NS)

`endif

// ### src/oabf_event_flags.v
// Operation
// - a detected orientation change that sets the fresh-orientation bit sets status bit 2.
// - a host read of the orientation state register clears the orientation-change flag, unless a change is detected in the same cycle.
// - every wake-to-sleep or sleep-to-wake move made with the auto-sleep enable set sets status bit 1.
// - after the programmed number of event-free data-rate periods the block enters sleep power.
// - in sleep, any configured event flag going active returns the block to wake power.
// - the system mode register shows whether the last move was into sleep or into wake.
// - a host read of the system mode register clears the auto-sleep flag, unless a flagged move happens in the same cycle.
// - auto-sleep runs only with a limit of at least 1, and its flag only with its enable set.
// - status bit 0 is set when boot ends and holds until power-on, soft reset or hibernate exit.
// - with the strap low the boot interrupt goes to line one by default, else as mapped.
// - with the strap low and boot interrupt enabled, one short pulse goes on the mapped line.
// - with the strap high, line two is pulled low once, open drain, for the long pulse time.
// - after power-on or hibernate exit the boot pulse is active low, polarity writes refused.
// - soft reset keeps polarity, driver type and line-two mapping for the next boot pulse.
// - no host read or write completes until boot has finished.
`timescale 1ns/100ps
`include "oabf_consts.vh"

module oabf_event_flags #(
  parameter PULSE_LONG_CYC = `OABF_PULSE_LONG_CYC
) (
  input  wire       clk,              // 100 MHz sensor clock
  input  wire       rst_n,            // power-on reset, active low
  input  wire       soft_reset,       // soft reset request pulse
  input  wire       hib_exit,         // hibernate exit pulse
  input  wire       boot_strap_select,// boot strap level
  input  wire       odr_tick,         // one pulse per data-rate period
  input  wire       orient_change,    // orientation change detected pulse
  input  wire [2:0] orient_code,      // current orientation code
  input  wire       cfg_event,        // any configured interrupt event flag active
  input  wire       host_rd,          // host read strobe
  input  wire       host_wr,          // host write strobe
  input  wire [7:0] host_addr,        // register offset
  input  wire [7:0] host_wdata,       // write data
  output reg  [7:0] host_rdata,       // read data
  output reg        host_ack,         // access completed pulse
  output reg        boot_busy,        // boot in progress
  output reg        sleep_mode,       // high while in sleep
  output reg  [1:0] power_select,     // active power mode select
  output reg        irq_line_one_o,   // line one level
  output reg        irq_line_one_oe,  // line one drive enable
  output reg        irq_line_two_o,   // line two level
  output reg        irq_line_two_oe   // line two drive enable
);

  // counts cut on purpose to the 17-bit counter width
  localparam integer BOOT_I    = `OABF_BOOT_CYC;
  localparam integer SHORT_I   = `OABF_PULSE_SHORT_CYC;
  localparam integer LONG_I    = PULSE_LONG_CYC;
  localparam [16:0]  BOOT_CYC  = BOOT_I[16:0];
  localparam [16:0]  SHORT_CYC = SHORT_I[16:0];
  localparam [16:0]  LONG_CYC  = LONG_I[16:0];

  reg        orient_flag_r;
  reg        aslp_flag_r;
  reg        boot_flag_r;
  reg        fresh_orient_r;
  reg        last_to_sleep_r;
  reg [7:0]  config2_r;
  reg [7:0]  config4_r;
  reg [7:0]  int_en_r;
  reg [7:0]  pin_sel_r;
  reg [15:0] limit_r;
  reg [15:0] idle_cnt_r;
  reg [16:0] boot_cnt_r;
  reg [16:0] pulse_cnt_r;
  reg        pulse_long_r;

  wire restart  = soft_reset | hib_exit;
  wire access   = (host_rd | host_wr) & ~boot_busy & ~restart;
  wire rd_ok    = host_rd & access;
  wire wr_ok    = host_wr & access;
  wire boot_end = boot_busy & ~restart & (boot_cnt_r == 17'h00001);
  wire pulse_on = (pulse_cnt_r != 17'h00000);
  wire aslp_on  = (limit_r != 16'h0000);
  wire go_sleep = aslp_on & ~sleep_mode & ~cfg_event & odr_tick &
                  (idle_cnt_r + 16'h0001 >= limit_r);
  wire go_wake  = aslp_on & sleep_mode & cfg_event;

  // register offset match
  function is_addr;
    input [7:0] a;
    input [7:0] want;
    begin
      is_addr = (a == want);
    end
  endfunction

  // ----------------------------------------------------------------
  // boot sequencing and boot-pulse timing
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_busy    <= 1'b1;
      boot_cnt_r   <= BOOT_CYC;
      boot_flag_r  <= 1'b0;
      pulse_cnt_r  <= 17'h00000;
      pulse_long_r <= 1'b0;
    end else if (restart) begin
      boot_busy    <= 1'b1;
      boot_cnt_r   <= BOOT_CYC;
      boot_flag_r  <= 1'b0;
      pulse_cnt_r  <= 17'h00000;
      pulse_long_r <= 1'b0;
    end else begin
      if (boot_busy) begin
        boot_cnt_r <= boot_cnt_r - 17'h00001;
      end
      if (boot_end) begin
        boot_busy   <= 1'b0;
        boot_flag_r <= 1'b1;
        if (boot_strap_select) begin
          pulse_cnt_r  <= LONG_CYC;
          pulse_long_r <= 1'b1;
        end else if (int_en_r[`OABF_EN_BOOT_BIT]) begin
          pulse_cnt_r  <= SHORT_CYC;
          pulse_long_r <= 1'b0;
        end
      end else if (pulse_on) begin
        pulse_cnt_r <= pulse_cnt_r - 17'h00001;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin settings: kept over soft reset, cleared by power-on and hibernate exit
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config4_r <= `OABF_CONFIG4_RST;
      pin_sel_r <= `OABF_PIN_SEL_RST;
    end else if (hib_exit) begin
      config4_r <= `OABF_CONFIG4_RST;
      pin_sel_r <= `OABF_PIN_SEL_RST;
    end else if (wr_ok) begin
      if (is_addr(host_addr, `OABF_ADDR_CONFIG4)) begin
        config4_r <= host_wdata;
      end
      if (is_addr(host_addr, `OABF_ADDR_PIN_SEL)) begin
        pin_sel_r <= host_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // other configuration, reset by any boot restart
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config2_r <= `OABF_CONFIG2_RST;
      int_en_r  <= `OABF_INT_EN_RST;
      limit_r   <= `OABF_LIMIT_RST;
    end else if (restart) begin
      config2_r <= `OABF_CONFIG2_RST;
      int_en_r  <= `OABF_INT_EN_RST;
      limit_r   <= `OABF_LIMIT_RST;
    end else if (wr_ok) begin
      if (is_addr(host_addr, `OABF_ADDR_CONFIG2)) begin
        config2_r <= host_wdata;
      end
      if (is_addr(host_addr, `OABF_ADDR_INT_EN)) begin
        int_en_r <= host_wdata;
      end
      if (is_addr(host_addr, `OABF_ADDR_LIMIT_LOW)) begin
        limit_r[7:0] <= host_wdata;
      end
      if (is_addr(host_addr, `OABF_ADDR_LIMIT_HIGH)) begin
        limit_r[15:8] <= host_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // event flags, set beats clearing read
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      orient_flag_r   <= 1'b0;
      fresh_orient_r  <= 1'b0;
      aslp_flag_r     <= 1'b0;
    end else if (restart) begin
      orient_flag_r   <= 1'b0;
      fresh_orient_r  <= 1'b0;
      aslp_flag_r     <= 1'b0;
    end else begin
      if (orient_change) begin
        orient_flag_r  <= 1'b1;
        fresh_orient_r <= 1'b1;
      end else if (rd_ok && is_addr(host_addr, `OABF_ADDR_ORIENT)) begin
        orient_flag_r  <= 1'b0;
        fresh_orient_r <= 1'b0;
      end
      if ((go_sleep | go_wake) & int_en_r[`OABF_EN_ASLP_BIT]) begin
        aslp_flag_r <= 1'b1;
      end else if (rd_ok && is_addr(host_addr, `OABF_ADDR_RUN_MODE)) begin
        aslp_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // auto wake/sleep state and inactivity count
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_mode      <= 1'b0;
      last_to_sleep_r <= 1'b0;
      idle_cnt_r      <= 16'h0000;
      power_select    <= 2'h0;
    end else if (restart) begin
      sleep_mode      <= 1'b0;
      last_to_sleep_r <= 1'b0;
      idle_cnt_r      <= 16'h0000;
      power_select    <= 2'h0;
    end else begin
      if (go_sleep) begin
        sleep_mode      <= 1'b1;
        last_to_sleep_r <= 1'b1;
        idle_cnt_r      <= 16'h0000;
      end else if (go_wake) begin
        sleep_mode      <= 1'b0;
        last_to_sleep_r <= 1'b0;
      end else if (cfg_event | ~aslp_on | sleep_mode) begin
        idle_cnt_r <= 16'h0000;
      end else if (odr_tick) begin
        idle_cnt_r <= idle_cnt_r + 16'h0001;
      end
      // sleep select in bits 3:2, wake select in bits 1:0
      power_select <= (go_sleep | (sleep_mode & ~go_wake)) ? config2_r[3:2] : config2_r[1:0];
    end
  end

  // ----------------------------------------------------------------
  // host read data and completion
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= 8'h00;
      host_ack   <= 1'b0;
    end else begin
      host_ack <= access;
      if (rd_ok) begin
        case (host_addr)
          `OABF_ADDR_STATUS:     host_rdata <= {5'h00, orient_flag_r, aslp_flag_r, boot_flag_r};
          `OABF_ADDR_RUN_MODE:   host_rdata <= {6'h00, last_to_sleep_r, sleep_mode};
          `OABF_ADDR_ORIENT:     host_rdata <= {fresh_orient_r, 4'h0, orient_code};
          `OABF_ADDR_CONFIG2:    host_rdata <= config2_r;
          `OABF_ADDR_CONFIG4:    host_rdata <= config4_r;
          `OABF_ADDR_INT_EN:     host_rdata <= int_en_r;
          `OABF_ADDR_PIN_SEL:    host_rdata <= pin_sel_r;
          `OABF_ADDR_LIMIT_LOW:  host_rdata <= limit_r[7:0];
          `OABF_ADDR_LIMIT_HIGH: host_rdata <= limit_r[15:8];
          default:               host_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt pin drive
  // ----------------------------------------------------------------
  wire to_two  = boot_strap_select | pin_sel_r[`OABF_PS_BOOT2_BIT];
  wire act_one = pulse_on & ~pulse_long_r & ~to_two;
  wire act_two = pulse_on & (pulse_long_r | to_two);
  wire pol_hi  = config4_r[`OABF_C4_POL_BIT] & ~pulse_long_r;
  wire od      = config4_r[`OABF_C4_OD_BIT] | pulse_long_r;
  // active level follows polarity: low when pol_hi is 0, idle is the opposite
  wire lvl_one = act_one ~^ pol_hi;
  wire lvl_two = act_two ~^ pol_hi;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_line_one_o  <= 1'b1;
      irq_line_one_oe <= 1'b0;
      irq_line_two_o  <= 1'b1;
      irq_line_two_oe <= 1'b0;
    end else begin
      irq_line_one_o  <= lvl_one;
      irq_line_one_oe <= od ? ~lvl_one : ~boot_busy;
      irq_line_two_o  <= lvl_two;
      irq_line_two_oe <= od ? ~lvl_two : ~boot_busy;
    end
  end

endmodule

// ### tb/oabf_chk_assertions.sv
`timescale 1ns/100ps
`include "oabf_consts.vh"

module oabf_chk #(
  parameter PULSE_LONG_CYC = 50
) (
  input wire       clk,               // clock
  input wire       rst_n,             // reset
  input wire       soft_reset,        // soft reset
  input wire       hib_exit,          // hibernate exit
  input wire       boot_strap_select, // strap
  input wire       odr_tick,          // data-rate tick
  input wire       orient_change,     // orientation change
  input wire [2:0] orient_code,       // orientation code
  input wire       cfg_event,         // event active
  input wire       host_rd,           // read strobe
  input wire       host_wr,           // write strobe
  input wire [7:0] host_addr,         // address
  input wire [7:0] host_wdata,        // write data
  input wire [7:0] host_rdata,        // read data
  input wire       host_ack,          // ack
  input wire       boot_busy,         // booting
  input wire       sleep_mode,        // asleep
  input wire [1:0] power_select,      // power mode
  input wire       irq_line_one_o,    // line one
  input wire       irq_line_one_oe,   // line one enable
  input wire       irq_line_two_o,    // line two
  input wire       irq_line_two_oe    // line two enable
);
  // ----------------------------------------------------------------
  // access qualifier and low-time counters
  // ----------------------------------------------------------------
  wire acc = (host_rd | host_wr) & ~boot_busy & ~soft_reset & ~hib_exit;
  reg [19:0] low1_r;
  reg [19:0] low2_r;

  // count cycles each line is driven low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low1_r <= 20'h00000;
      low2_r <= 20'h00000;
    end else begin
      low1_r <= (irq_line_one_oe & ~irq_line_one_o) ? low1_r + 20'h00001 : 20'h00000;
      low2_r <= (irq_line_two_oe & ~irq_line_two_o) ? low2_r + 20'h00001 : 20'h00000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ack_next_cycle: assert property (acc |=> host_ack)
    else $error("accepted access not acked");
  a_busy_refuses: assert property ((host_rd | host_wr) && boot_busy |=> !host_ack)
    else $error("access acked during boot");
  a_ack_has_cause: assert property (host_ack |-> $past(acc))
    else $error("ack without access");
  a_rdata_holds: assert property (!host_ack |-> $stable(host_rdata))
    else $error("read data moved without ack");
  a_boot_flag_read: assert property (acc && host_rd && host_addr == `OABF_ADDR_STATUS
    |=> host_rdata[0])
    else $error("boot flag read as zero");
  a_mode_read: assert property (acc && host_rd && host_addr == `OABF_ADDR_RUN_MODE
    |=> host_rdata[0] == $past(sleep_mode))
    else $error("mode register wrong");
  a_sleep_on_tick: assert property ($rose(sleep_mode)
    |-> $past(odr_tick) && !$past(cfg_event))
    else $error("sleep without idle tick");
  a_wake_on_event: assert property (sleep_mode && cfg_event |-> ##[1:2] !sleep_mode)
    else $error("no wake on event");
  a_restart_boot: assert property (soft_reset || hib_exit |=> boot_busy)
    else $error("boot not restarted");
  a_short_pulse_len: assert property ($rose(irq_line_one_o) && irq_line_one_oe
    |-> low1_r == `OABF_PULSE_SHORT_CYC)
    else $error("short pulse length wrong");
  a_long_pulse_len: assert property ($fell(irq_line_two_oe) && boot_strap_select && !boot_busy
    |-> low2_r == PULSE_LONG_CYC)
    else $error("long pulse length wrong");
endmodule

bind oabf_event_flags oabf_chk #(.PULSE_LONG_CYC(PULSE_LONG_CYC)) u_chk (.*);

// ### tb/oabf_host_model.sv
`timescale 1ns/100ps

module oabf_host_model (
  input  wire       clk,        // clock
  input  wire       boot_busy,  // booting
  input  wire       host_ack,   // ack
  input  wire [7:0] host_rdata, // read data
  output reg        host_rd,    // read strobe
  output reg        host_wr,    // write strobe
  output reg  [7:0] host_addr,  // address
  output reg  [7:0] host_wdata  // write data
);
  // idle bus at time zero
  initial begin
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_addr = 8'hFF;
    host_wdata = 8'hFF;
  end

  // hold off until boot ends, bounded
  task wait_boot;
    integer n;
    begin
      n = 0;
      while (boot_busy !== 1'b0 && n < 5000) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      @(posedge clk);
      #1;
    end
  endtask

  // one strobe cycle; bus parked inverted after release
  task xfer(input wr, input [7:0] a, input [7:0] d, output [7:0] q, output ok);
    begin
      @(posedge clk);
      #1;
      host_rd = !wr;
      host_wr = wr;
      host_addr = a;
      host_wdata = d;
      @(posedge clk);
      #1;
      host_rd = 1'b0;
      host_wr = 1'b0;
      host_addr = ~a;
      host_wdata = ~d;
      ok = host_ack;
      q = host_rdata;
    end
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
`include "oabf_consts.vh"

module testbench;
  localparam LONG = 50;
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg        soft_reset = 1'b0;
  reg        hib_exit = 1'b0;
  reg        boot_strap_select = 1'b0;
  reg        odr_tick = 1'b0;
  reg        orient_change = 1'b0;
  reg  [2:0] orient_code = 3'h0;
  reg        cfg_event = 1'b0;
  wire       host_rd, host_wr, host_ack, boot_busy, sleep_mode;
  wire [7:0] host_addr, host_wdata, host_rdata;
  wire [1:0] power_select;
  wire       irq_line_one_o, irq_line_one_oe, irq_line_two_o, irq_line_two_oe;
  integer    num_errors = 0;
  integer    samples_checked = 0;
  integer    cyc = 0;
  reg  [7:0] q;
  reg        ok;

  oabf_event_flags #(.PULSE_LONG_CYC(LONG)) DUT (.*);
  oabf_host_model host (.*);

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  always #5 clk = ~clk;

  // cut a hang short
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
  end

  task check(input [8:0] got, input [8:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      if (got !== exp)
        num_errors = num_errors + 1;
    end
  endtask

  task rd(input [7:0] a, input [7:0] exp);
    begin
      host.xfer(1'b0, a, 8'h00, q, ok);
      check({ok, q}, {1'b1, exp});
    end
  endtask

  task wr(input [7:0] a, input [7:0] d, input ea);
    begin
      host.xfer(1'b1, a, d, q, ok);
      check({8'h00, ok}, {8'h00, ea});
    end
  endtask

  task tick;
    begin
      @(posedge clk);
      #1 odr_tick = 1'b1;
      @(posedge clk);
      #1 odr_tick = 1'b0;
    end
  endtask

  // boot refusal, flag and default pulse on line one
  task t_boot;
    begin
      wr(`OABF_ADDR_PIN_SEL, 8'h01, 1'b0);
      host.wait_boot;
      check({7'h00, irq_line_one_o, irq_line_two_o}, 9'h001);
      rd(`OABF_ADDR_STATUS, 8'h01);
      repeat (1000) @(posedge clk);
      #1 check({8'h00, irq_line_one_o}, 9'h001);
    end
  endtask

  // orientation flag set, cleared, and set winning over clear
  task t_orient;
    begin
      tick;
      @(posedge clk);
      #1 orient_change = 1'b1;
      @(posedge clk);
      #1 orient_change = 1'b0;
      rd(`OABF_ADDR_STATUS, 8'h05);
      rd(`OABF_ADDR_ORIENT, 8'h80);
      rd(`OABF_ADDR_STATUS, 8'h01);
      fork
        host.xfer(1'b0, `OABF_ADDR_ORIENT, 8'h00, q, ok);
        begin
          @(posedge clk);
          #1 orient_change = 1'b1;
          @(posedge clk);
          #1 orient_change = 1'b0;
        end
      join
      rd(`OABF_ADDR_STATUS, 8'h05);
      host.xfer(1'b0, `OABF_ADDR_ORIENT, 8'h00, q, ok);
    end
  endtask

  // inactivity sleep, event wake, direction and limit zero
  task t_aslp;
    begin
      wr(`OABF_ADDR_INT_EN, 8'h03, 1'b1);
      wr(`OABF_ADDR_CONFIG2, 8'h0D, 1'b1);
      wr(`OABF_ADDR_LIMIT_LOW, 8'h02, 1'b1);
      tick;
      check({6'h00, power_select, sleep_mode}, 9'h002);
      tick;
      check({6'h00, power_select, sleep_mode}, 9'h007);
      rd(`OABF_ADDR_STATUS, 8'h03);
      rd(`OABF_ADDR_RUN_MODE, 8'h03);
      rd(`OABF_ADDR_STATUS, 8'h01);
      cfg_event = 1'b1;
      repeat (2) @(posedge clk);
      #1 check({6'h00, power_select, sleep_mode}, 9'h002);
      cfg_event = 1'b0;
      rd(`OABF_ADDR_STATUS, 8'h03);
      rd(`OABF_ADDR_RUN_MODE, 8'h00);
      wr(`OABF_ADDR_LIMIT_LOW, 8'h00, 1'b1);
      repeat (3) tick;
      check({6'h00, power_select, sleep_mode}, 9'h002);
      wr(`OABF_ADDR_INT_EN, 8'h01, 1'b1);
      wr(`OABF_ADDR_LIMIT_LOW, 8'h01, 1'b1);
      tick;
      check({6'h00, power_select, sleep_mode}, 9'h007);
      rd(`OABF_ADDR_STATUS, 8'h01);
    end
  endtask

  // soft reset keeps the line-two mapping
  task t_soft;
    begin
      wr(`OABF_ADDR_PIN_SEL, 8'h01, 1'b1);
      @(posedge clk);
      #1 soft_reset = 1'b1;
      @(posedge clk);
      #1 soft_reset = 1'b0;
      wr(`OABF_ADDR_PIN_SEL, 8'h00, 1'b0);
      host.wait_boot;
      check({7'h00, irq_line_one_o, irq_line_two_o}, 9'h002);
      rd(`OABF_ADDR_PIN_SEL, 8'h01);
      repeat (1000) @(posedge clk);
    end
  endtask

  // strap high: long open-drain low pulse on line two
  task t_strap;
    begin
      #1 boot_strap_select = 1'b1;
      @(posedge clk);
      #1 hib_exit = 1'b1;
      @(posedge clk);
      #1 hib_exit = 1'b0;
      host.wait_boot;
      check({7'h00, irq_line_two_oe, irq_line_two_o}, 9'h002);
      repeat (LONG + 5) @(posedge clk);
      #1 check({8'h00, irq_line_two_oe}, 9'h000);
    end
  endtask

  task report_and_stop;
    begin
      $display("mismatches=%0d comparisons=%0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    t_boot;
    t_orient;
    t_aslp;
    t_soft;
    t_strap;
    report_and_stop;
  end
endmodule
